// [rtl/fsr_pkg.sv]
// Package with status register constants, opcodes and timing for the flash status block.
package fsr_pkg;
  // ==========================================================================
  // Opcodes
  localparam logic [7:0] OP_WRITE_LATCH_SET_CMD_SET = 8'h06;
  localparam logic [7:0] OP_WL_CLEAR = 8'h04;
  localparam logic [7:0] OP_VOL_EN = 8'h50;
  localparam logic [7:0] OP_SR1_WRITE = 8'h01;
  localparam logic [7:0] OP_SR2_WRITE = 8'h31;
  localparam logic [7:0] OP_SR1_READ = 8'h05;
  localparam logic [7:0] OP_SR2_READ_A = 8'h09;
  localparam logic [7:0] OP_SR2_READ_B = 8'h35;
  localparam logic [7:0] OP_QUAD_ENTER = 8'h38;
  localparam logic [7:0] OP_QUAD_EXIT = 8'hFF;
  localparam logic [7:0] OP_PAGE_WR = 8'h02;
  localparam logic [7:0] OP_QPAGE_WR = 8'h32;
  localparam logic [7:0] OP_SMALL_WIPE = 8'h20;
  localparam logic [7:0] OP_HALF_WIPE = 8'h52;
  localparam logic [7:0] OP_LARGE_WIPE = 8'hD8;
  localparam logic [7:0] OP_CHIP_WIPE = 8'hC7;
  localparam logic [7:0] OP_SUSPEND = 8'hB0;
  localparam logic [7:0] OP_RESUME = 8'h30;
  // ==========================================================================
  // Status register 1 fields
  localparam int SR1_BUSY = 0;
  localparam int SR1_WEL = 1;
  localparam int SR1_BG_LO = 2;
  localparam int SR1_TB = 6;
  localparam int SR1_LOCK = 7;
  // Status register 2 fields
  localparam int SR2_QE = 1;
  localparam int SR2_PSUS = 2;
  localparam int SR2_OTP_LO = 3;
  localparam int SR2_CMP = 6;
  localparam int SR2_ESUS = 7;
  // ==========================================================================
  // Reset values of the non-volatile bits
  localparam logic [3:0] RST_BG = 4'h0;
  localparam logic RST_TB = 1'b0;
  localparam logic RST_LOCK = 1'b0;
  localparam logic RST_CMP = 1'b0;
  localparam logic RST_QE = 1'b1;
  localparam logic [2:0] RST_OTP = 3'h0;
  // ==========================================================================
  // Timing of the internal busy cycles
  localparam int CLK_NS = 25;
  localparam int T_SRW_NS = 2000;
  localparam int T_PROG_NS = 4000;
  localparam int T_ERASE_NS = 8000;
  localparam logic [15:0] CYC_SRW = 16'((T_SRW_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [15:0] CYC_PROG = 16'((T_PROG_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [15:0] CYC_ERASE = 16'((T_ERASE_NS + CLK_NS - 1) / CLK_NS);
  // ==========================================================================
  // Operation kinds and sequencer states
  typedef enum logic [1:0] {
    OPK_NONE = 2'b00,
    OPK_SRW = 2'b01,
    OPK_PROG = 2'b10,
    OPK_ERASE = 2'b11
  } fsr_op_type;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01,
    ST_SUSP = 2'b10
  } fsr_state_type;
endpackage

// [rtl/fsr_link_if.sv]
// Interface carrying decoded link events from the serial front end to the register core.
`timescale 1ns/100ps
interface fsr_link_if;
  logic frame_start;
  logic frame_end;
  logic byte_done;
  logic [7:0] rx_byte;
  logic [3:0] bit_cnt;
  logic quad;
  logic sclk_fall;
  modport front (output frame_start, frame_end, byte_done, rx_byte, bit_cnt, sclk_fall,
                 input quad);
  modport core (input frame_start, frame_end, byte_done, rx_byte, bit_cnt, sclk_fall,
                output quad);
endinterface

// [rtl/fsr_front.sv]
// Serial front end: synchronises the link pins and assembles incoming bytes.
`timescale 1ns/100ps
module fsr_front
  import fsr_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Link pins
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic [3:0] dq_in,
  // Core side
  fsr_link_if.front lnk
);
  // ==========================================================================
  // Synchronisers
  logic [5:0] s1_q, s2_q, s1_d, s2_d;
  logic sclk_old_q, cs_old_q, sclk_old_d, cs_old_d;
  logic [7:0] sh_q, sh_d;
  logic [3:0] cnt_q, cnt_d;
  logic rise, act;
  always_comb begin
    s1_d = {dq_in, cs_n, sclk};
    s2_d = s1_q;
    sclk_old_d = s2_q[0];
    cs_old_d = s2_q[1];
    rise = s2_q[0] & ~sclk_old_q & ~s2_q[1];
    act = ~s2_q[1];
    sh_d = sh_q;
    cnt_d = cnt_q;
    if (!act) begin
      cnt_d = 4'h0;
    end else if (rise) begin
      if (lnk.quad) begin
        sh_d = {sh_q[3:0], s2_q[5:2]};
        cnt_d = (cnt_q == 4'h4) ? 4'h0 : 4'h4;
      end else begin
        sh_d = {sh_q[6:0], s2_q[2]};
        cnt_d = (cnt_q == 4'h7) ? 4'h0 : cnt_q + 4'h1;
      end
    end
  end
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s1_q <= 6'h03;
      s2_q <= 6'h03;
      sclk_old_q <= 1'b1;
      cs_old_q <= 1'b1;
      sh_q <= 8'h00;
      cnt_q <= 4'h0;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      sclk_old_q <= sclk_old_d;
      cs_old_q <= cs_old_d;
      sh_q <= sh_d;
      cnt_q <= cnt_d;
    end
  end
  assign lnk.frame_start = cs_old_q & ~s2_q[1];
  assign lnk.frame_end = ~cs_old_q & s2_q[1];
  assign lnk.byte_done = rise & (lnk.quad ? (cnt_q == 4'h4) : (cnt_q == 4'h7));
  assign lnk.rx_byte = lnk.quad ? {sh_q[3:0], s2_q[5:2]} : {sh_q[6:0], s2_q[2]};
  assign lnk.bit_cnt = cnt_q;
  assign lnk.sclk_fall = ~s2_q[0] & sclk_old_q & act;
endmodule

// [rtl/fsr_top.sv]
// Status and protection register logic of a serial flash, driven from the serial link.
`timescale 1ns/100ps
module fsr_top
  import fsr_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Serial link
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic [3:0] dq_in,
  output logic [3:0] dq_out,
  output logic [3:0] dq_oe,
  // Protect pin, control function
  input wire logic protect_pin_n,
  // Status
  output logic four_lane_enable,
  output logic protect_pins_are_data,
  output logic array_protected
);
  fsr_link_if lnk ();
  fsr_front u_front (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .sclk(sclk),
    .cs_n(cs_n),
    .dq_in(dq_in),
    .lnk(lnk)
  );
  // ==========================================================================
  // State
  logic [1:0] wp_sync_q, wp_sync_d;
  logic [3:0] bg_v_q, bg_v_d;
  logic tb_v_q, tb_v_d;
  logic lock_v_q, lock_v_d;
  logic cmp_q, cmp_d, qe_q, qe_d;
  logic [2:0] otp_q, otp_d;
  logic wel_q, wel_d, vol_q, vol_d, quad_q, quad_d;
  logic [7:0] opc_q, opc_d, wdat1_q, wdat1_d, wdat2_q, wdat2_d;
  logic [1:0] nbytes_q, nbytes_d;
  logic [7:0] tx_q, tx_d;
  logic [3:0] dqo_q, dqo_d, oe_q, oe_d;
  logic [15:0] tmr_q, tmr_d;
  fsr_state_type st_q, st_d;
  fsr_op_type op_q, op_d, susop_q, susop_d;
  logic [15:0] sus_tmr_q, sus_tmr_d;
  logic prot_q, prot_d;
  logic [7:0] sr1, sr2;
  logic busy, hpm, any_prot;
  always_comb begin
    hpm = lock_v_q & ~wp_sync_q[1] & ~qe_q;
    busy = (st_q == ST_RUN);
    any_prot = (bg_v_q != 4'h0) | cmp_q;
    sr1 = 8'h00;
    sr1[SR1_BUSY] = busy;
    sr1[SR1_WEL] = wel_q;
    sr1[SR1_BG_LO +: 4] = bg_v_q;
    sr1[SR1_TB] = tb_v_q;
    sr1[SR1_LOCK] = lock_v_q;
    sr2 = 8'h00;
    sr2[SR2_ESUS] = (st_q == ST_SUSP) & (susop_q == OPK_ERASE);
    sr2[SR2_PSUS] = (st_q == ST_SUSP) & (susop_q == OPK_PROG);
    sr2[SR2_CMP] = cmp_q;
    sr2[SR2_OTP_LO +: 3] = otp_q;
    sr2[SR2_QE] = qe_q;
  end
  assign lnk.quad = quad_q;
  // ==========================================================================
  // Command decode and register updates
  always_comb begin
    wp_sync_d = {wp_sync_q[0], protect_pin_n};
    bg_v_d = bg_v_q;
    tb_v_d = tb_v_q;
    lock_v_d = lock_v_q;
    cmp_d = cmp_q;
    qe_d = qe_q;
    otp_d = otp_q;
    wel_d = wel_q;
    vol_d = vol_q;
    quad_d = quad_q;
    opc_d = opc_q;
    wdat1_d = wdat1_q;
    wdat2_d = wdat2_q;
    nbytes_d = nbytes_q;
    tx_d = tx_q;
    dqo_d = dqo_q;
    oe_d = oe_q;
    tmr_d = tmr_q;
    st_d = st_q;
    op_d = op_q;
    susop_d = susop_q;
    sus_tmr_d = sus_tmr_q;
    prot_d = any_prot;
    if (lnk.frame_start || lnk.frame_end) begin
      opc_d = 8'h00;
      nbytes_d = 2'd0;
    end
    if (lnk.byte_done) begin
      if (opc_q == 8'h00 && nbytes_q == 2'd0) begin
        opc_d = lnk.rx_byte;
        nbytes_d = 2'd1;
        if (lnk.rx_byte == OP_SR1_READ) begin
          tx_d = sr1;
        end else if (lnk.rx_byte == OP_SR2_READ_A || lnk.rx_byte == OP_SR2_READ_B) begin
          tx_d = sr2;
        end
      end else begin
        if (nbytes_q == 2'd1) begin
          wdat1_d = lnk.rx_byte;
        end else if (nbytes_q == 2'd2) begin
          wdat2_d = lnk.rx_byte;
        end
        nbytes_d = (nbytes_q == 2'd3) ? nbytes_q : nbytes_q + 2'd1;
        if (opc_q == OP_SR1_READ) begin
          tx_d = sr1;
        end else if (opc_q == OP_SR2_READ_A || opc_q == OP_SR2_READ_B) begin
          tx_d = sr2;
        end
      end
    end
    oe_d = 4'h0;
    if (!cs_n_active_read()) begin
      dqo_d = 4'h0;
    end else if (lnk.sclk_fall) begin
      dqo_d = quad_q ? (lnk.bit_cnt[2] ? tx_q[3:0] : tx_q[7:4])
                     : {2'b00, tx_q[3'd7 - lnk.bit_cnt[2:0]], 1'b0};
    end
    if (cs_n_active_read() && (lnk.sclk_fall || oe_q != 4'h0)) begin
      oe_d = quad_q ? 4'hF : 4'h2;
    end
    if (lnk.frame_end) begin
      if (!busy) begin
        case (opc_q)
          OP_WRITE_LATCH_SET_CMD_SET: begin
            wel_d = 1'b1;
          end
          OP_WL_CLEAR: begin
            wel_d = 1'b0;
          end
          OP_VOL_EN: begin
            vol_d = 1'b1;
          end
          OP_QUAD_ENTER: begin
            quad_d = qe_q;
          end
          OP_QUAD_EXIT: begin
            quad_d = 1'b0;
          end
          OP_SR1_WRITE: begin
            if (!hpm && nbytes_q >= 2'd2 && (wel_q || vol_q)) begin
              bg_v_d = wdat1_q[SR1_BG_LO +: 4];
              tb_v_d = wdat1_q[SR1_TB];
              lock_v_d = wdat1_q[SR1_LOCK];
              if (nbytes_q == 2'd3) begin
                cmp_d = wdat2_q[SR2_CMP];
                qe_d = wdat2_q[SR2_QE];
                otp_d = otp_q | wdat2_q[SR2_OTP_LO +: 3];
              end
              if (!vol_q) begin
                st_d = ST_RUN;
                op_d = OPK_SRW;
                tmr_d = CYC_SRW;
              end
            end
          end
          OP_SR2_WRITE: begin
            if (!hpm && nbytes_q >= 2'd2 && wel_q) begin
              cmp_d = wdat1_q[SR2_CMP];
              qe_d = wdat1_q[SR2_QE];
              otp_d = otp_q | wdat1_q[SR2_OTP_LO +: 3];
              st_d = ST_RUN;
              op_d = OPK_SRW;
              tmr_d = CYC_SRW;
            end
          end
          OP_PAGE_WR, OP_QPAGE_WR: begin
            if (wel_q && st_q == ST_IDLE && !(any_prot && bg_v_q != 4'h0)) begin
              st_d = ST_RUN;
              op_d = OPK_PROG;
              tmr_d = CYC_PROG;
            end
          end
          OP_SMALL_WIPE, OP_HALF_WIPE, OP_LARGE_WIPE: begin
            if (wel_q && st_q == ST_IDLE && bg_v_q == 4'h0) begin
              st_d = ST_RUN;
              op_d = OPK_ERASE;
              tmr_d = CYC_ERASE;
            end
          end
          OP_CHIP_WIPE: begin
            if (wel_q && st_q == ST_IDLE && !any_prot && otp_q == 3'h0) begin
              st_d = ST_RUN;
              op_d = OPK_ERASE;
              tmr_d = CYC_ERASE;
            end
          end
          OP_RESUME: begin
            if (st_q == ST_SUSP) begin
              st_d = ST_RUN;
              op_d = susop_q;
              tmr_d = sus_tmr_q;
            end
          end
          default: begin
          end
        endcase
        if (opc_q != OP_VOL_EN && opc_q != 8'h00) begin
          vol_d = 1'b0;
        end
      end else if (opc_q == OP_SUSPEND && op_q != OPK_SRW) begin
        st_d = ST_SUSP;
        susop_d = op_q;
        sus_tmr_d = tmr_q;
        op_d = OPK_NONE;
      end
    end
    if (st_q == ST_RUN) begin
      if (tmr_q <= 16'h0001) begin
        st_d = ST_IDLE;
        op_d = OPK_NONE;
        wel_d = 1'b0;
      end else begin
        tmr_d = tmr_q - 16'h0001;
      end
    end
  end
  function automatic logic cs_n_active_read();
    cs_n_active_read = (opc_q == OP_SR1_READ || opc_q == OP_SR2_READ_A
                        || opc_q == OP_SR2_READ_B) && !lnk.frame_end && !lnk.frame_start
                        && nbytes_q != 2'd0;
  endfunction
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wp_sync_q <= 2'b11;
      bg_v_q <= RST_BG;
      tb_v_q <= RST_TB;
      lock_v_q <= RST_LOCK;
      cmp_q <= RST_CMP;
      qe_q <= RST_QE;
      otp_q <= RST_OTP;
      wel_q <= 1'b0;
      vol_q <= 1'b0;
      quad_q <= 1'b0;
      opc_q <= 8'h00;
      wdat1_q <= 8'h00;
      wdat2_q <= 8'h00;
      nbytes_q <= 2'd0;
      tx_q <= 8'h00;
      dqo_q <= 4'h0;
      oe_q <= 4'h0;
      tmr_q <= 16'h0000;
      st_q <= ST_IDLE;
      op_q <= OPK_NONE;
      susop_q <= OPK_NONE;
      sus_tmr_q <= 16'h0000;
      prot_q <= 1'b0;
    end else begin
      wp_sync_q <= wp_sync_d;
      bg_v_q <= bg_v_d;
      tb_v_q <= tb_v_d;
      lock_v_q <= lock_v_d;
      cmp_q <= cmp_d;
      qe_q <= qe_d;
      otp_q <= otp_d;
      wel_q <= wel_d;
      vol_q <= vol_d;
      quad_q <= quad_d;
      opc_q <= opc_d;
      wdat1_q <= wdat1_d;
      wdat2_q <= wdat2_d;
      nbytes_q <= nbytes_d;
      tx_q <= tx_d;
      dqo_q <= dqo_d;
      oe_q <= oe_d;
      tmr_q <= tmr_d;
      st_q <= st_d;
      op_q <= op_d;
      susop_q <= susop_d;
      sus_tmr_q <= sus_tmr_d;
      prot_q <= prot_d;
    end
  end
  assign dq_out = dqo_q;
  assign dq_oe = oe_q;
  assign four_lane_enable = qe_q;
  assign protect_pins_are_data = qe_q;
  assign array_protected = prot_q;
endmodule

// [testbench/fsr_top_assertions.sv]
// Checker for the pin timing and reset behaviour of the flash status block.
`timescale 1ns/100ps
module fsr_top_checker (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Serial link
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic [3:0] dq_in,
  input wire logic [3:0] dq_out,
  input wire logic [3:0] dq_oe,
  // Pins and status
  input wire logic protect_pin_n,
  input wire logic four_lane_enable,
  input wire logic protect_pins_are_data,
  input wire logic array_protected
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);
  // ==========================================================================
  // Assertions
  a_lane_flags_same: assert property (protect_pins_are_data == four_lane_enable)
    else $error("lane flags differ");
  a_reset_leaves_defaults: assert property ($rose(nrst) |-> four_lane_enable &&
    !array_protected && dq_oe == 4'h0) else $error("wrong values after reset");
  a_oe_idle_off: assert property (cs_n [*8] |-> dq_oe == 4'h0)
    else $error("lanes driven outside a frame");
  a_out_moves_low: assert property ($changed(dq_out) |-> !$past(sclk, 2))
    else $error("output moved away from a falling clock");
  a_oe_moves_low: assert property ($changed(dq_oe) |-> !$past(sclk, 2))
    else $error("enable moved away from a falling clock");
  a_out_holds_fall: assert property ($fell(sclk) |=> $stable(dq_out) [*2])
    else $error("output moved too early after a fall");
  a_oe_lane_shape: assert property (dq_oe inside {4'h0, 4'h2, 4'hF})
    else $error("illegal lane enable pattern");
  a_oe_rise_framed: assert property ($rose(dq_oe[1]) |-> !cs_n)
    else $error("read began outside a frame");
  a_oe_held_frame: assert property ($fell(dq_oe[1]) |-> cs_n)
    else $error("read stopped inside a frame");
  // ==========================================================================
  // Covers
  c_read: cover property ($rose(dq_oe[1]));
  c_lane_off: cover property ($fell(four_lane_enable));
  c_guard: cover property ($rose(array_protected));
  c_quad_read: cover property (dq_oe == 4'hF);
endmodule
bind fsr_top fsr_top_checker i_chk (.ref_clk(ref_clk), .nrst(nrst), .sclk(sclk),
  .cs_n(cs_n), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
  .protect_pin_n(protect_pin_n), .four_lane_enable(four_lane_enable),
  .protect_pins_are_data(protect_pins_are_data), .array_protected(array_protected));

// [testbench/fsr_host_model.sv]
// Behavioural one- or four-lane host that frames commands and reads status bytes.
`timescale 1ns/100ps
module fsr_host_model (
  // Clock
  input wire logic ref_clk,
  // Link pins
  output logic sclk,
  output logic cs_n,
  output logic [3:0] dq_in,
  input wire logic [3:0] dq_out
);
  // Lanes per serial clock, 1 or 4, set by the bench.
  int lanes = 1;
  initial begin
    sclk = 1'h0;
    cs_n = 1'h1;
    dq_in = 4'h5;
  end
  // ==========================================================================
  // One frame: n_tx bytes out MSB first, then n_rx bytes from the output lanes.
  task automatic frame(input logic [39:0] tx, input int n_tx, input int n_rx,
                       output logic [15:0] rx);
    logic b;
    b = 1'h0;
    rx = 16'h0000;
    @(posedge ref_clk);
    cs_n <= 1'h0;
    for (int i = 0; i < 8 * (n_tx + n_rx); i += lanes) begin
      b = (i < 8 * n_tx) ? tx[39 - i] : ~b;
      sclk <= 1'h0;
      dq_in <= (lanes == 4) ? tx[39 - i -: 4] : {~dq_in[3:1], b};
      repeat (4) @(posedge ref_clk);
      sclk <= 1'h1;
      repeat (4) @(posedge ref_clk);
      if (i >= 8 * n_tx) begin
        rx = (lanes == 4) ? {rx[11:0], dq_out} : {rx[14:0], dq_out[1]};
      end
    end
    sclk <= 1'h0;
    repeat (4) @(posedge ref_clk);
    cs_n <= 1'h1;
    dq_in <= ~dq_in;
    repeat (8) @(posedge ref_clk);
  endtask
endmodule

// [testbench/test_flash_status_protection_regs.sv]
// Self-checking bench for the flash status and protection register block.
`timescale 1ns/100ps
`define CHK(what, exp, got) \
  begin \
    n_compared++; \
    if ((got) !== (exp)) begin \
      mismatches++; \
      $display("unexpected %s: expected %h, seen %h", what, exp, got); \
    end \
  end
module test_flash_status_protection_regs
  import fsr_pkg::*;
;
  logic ref_clk = 1'h0;
  logic nrst = 1'h0;
  logic protect_pin_n = 1'h1;
  logic sclk;
  logic cs_n;
  logic [3:0] dq_in;
  logic [3:0] dq_out;
  logic [3:0] dq_oe;
  logic four_lane_enable;
  logic protect_pins_are_data;
  logic array_protected;
  logic [15:0] rx;
  logic [7:0] g;
  logic [2:0] otp;
  logic [7:0] ops [6] = '{OP_PAGE_WR, OP_QPAGE_WR, OP_SMALL_WIPE, OP_HALF_WIPE,
                          OP_LARGE_WIPE, OP_CHIP_WIPE};
  int mismatches = 0;
  int n_compared = 0;
  always #12.5 ref_clk = ~ref_clk;
  fsr_top i_dut (.ref_clk(ref_clk), .nrst(nrst), .sclk(sclk), .cs_n(cs_n), .dq_in(dq_in),
    .dq_out(dq_out), .dq_oe(dq_oe), .protect_pin_n(protect_pin_n),
    .four_lane_enable(four_lane_enable), .protect_pins_are_data(protect_pins_are_data),
    .array_protected(array_protected));
  fsr_host_model i_host (.ref_clk(ref_clk), .sclk(sclk), .cs_n(cs_n), .dq_in(dq_in),
    .dq_out(dq_out));
  // ==========================================================================
  // Expected status register 2 from its fields.
  function automatic logic [7:0] sr2_of(logic es, logic ps, logic qe, logic [2:0] lk);
    return {es, 1'h0, lk, ps, qe, 1'h0};
  endfunction
  task automatic tally_and_finish();
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic rd(input logic [7:0] op, input int n);
    i_host.frame({op, 32'h0}, 1, n, rx);
  endtask
  task automatic cmd(input logic [7:0] op);
    i_host.frame({op, 32'h0}, 1, 0, rx);
  endtask
  task automatic poll();
    for (int k = 0; k < 30; k++) begin
      rd(OP_SR1_READ, 1);
      if (rx[0] === 1'h0) return;
    end
    mismatches++;
    $display("unexpected busy wait: expected 0, seen 1");
    tally_and_finish();
  endtask
  task automatic wr(input logic [7:0] op, input logic [7:0] d);
    cmd(OP_WRITE_LATCH_SET_CMD_SET);
    i_host.frame({op, d, 24'h0}, 2, 0, rx);
    poll();
  endtask
  // ==========================================================================
  // Main sequence.
  initial begin
    void'($urandom(83190));
    repeat (12) @(posedge ref_clk);
    nrst <= 1'h1;
    repeat (6) @(posedge ref_clk);
    `CHK("lane enable", 1'h1, four_lane_enable)
    `CHK("array protect", 1'h0, array_protected)
    rd(OP_SR1_READ, 2);
    `CHK("status1 reset", 16'h0000, rx)
    for (int k = 0; k < 2; k++) begin
      rd(k ? OP_SR2_READ_B : OP_SR2_READ_A, 2);
      `CHK("status2 reset", {2{sr2_of(0, 0, 1, 0)}}, rx)
    end
    $display("test reset done");
    i_host.frame({OP_SR1_WRITE, 8'h3C, 24'h0}, 2, 0, rx);
    poll();
    rd(OP_SR1_READ, 1);
    `CHK("write without latch", 8'h00, rx[7:0])
    cmd(OP_WRITE_LATCH_SET_CMD_SET);
    rd(OP_SR1_READ, 1);
    `CHK("latch set", 8'h02, rx[7:0])
    cmd(OP_WL_CLEAR);
    rd(OP_SR1_READ, 1);
    `CHK("latch clear", 8'h00, rx[7:0])
    $display("test latch done");
    cmd(OP_QUAD_ENTER);
    i_host.lanes = 4;
    cmd(OP_WRITE_LATCH_SET_CMD_SET);
    rd(OP_SR1_READ, 2);
    `CHK("four lane status", 16'h0202, rx)
    cmd(OP_WL_CLEAR);
    cmd(OP_QUAD_EXIT);
    i_host.lanes = 1;
    rd(OP_SR1_READ, 1);
    `CHK("single lane again", 8'h00, rx[7:0])
    $display("test four lane done");
    g = {1'h0, 7'($urandom)} | 8'h04;
    wr(OP_SR1_WRITE, g);
    rd(OP_SR1_READ, 1);
    `CHK("guard write", g & 8'h7C, rx[7:0])
    `CHK("array protect", 1'h1, array_protected)
    for (int k = 0; k < 6; k++) begin
      cmd(OP_WRITE_LATCH_SET_CMD_SET);
      i_host.frame({ops[k], 32'h000100A5}, k < 2 ? 5 : (k < 5 ? 4 : 1), 0, rx);
      rd(OP_SR1_READ, 1);
      `CHK("guarded refusal", 1'h0, rx[0])
    end
    $display("test guard done");
    cmd(OP_WL_CLEAR);
    cmd(OP_VOL_EN);
    i_host.frame({OP_SR1_WRITE, 8'h00, 24'h0}, 2, 0, rx);
    poll();
    rd(OP_SR1_READ, 1);
    `CHK("volatile write", 8'h00, rx[7:0])
    `CHK("array protect", 1'h0, array_protected)
    for (int k = 0; k < 2; k++) begin
      cmd(OP_WRITE_LATCH_SET_CMD_SET);
      i_host.frame(k ? {OP_PAGE_WR, 32'h000100A5} : {OP_CHIP_WIPE, 32'h0}, k ? 5 : 1, 0, rx);
      if (k == 0) begin
        rd(OP_SR1_READ, 1);
        `CHK("erase busy", 8'h03, rx[7:0])
      end
      cmd(OP_SUSPEND);
      rd(OP_SR2_READ_B, 1);
      `CHK("suspended", sr2_of(~k[0], k[0], 1, 0), rx[7:0])
      cmd(OP_RESUME);
      poll();
      rd(OP_SR2_READ_A, 1);
      `CHK("resumed", sr2_of(0, 0, 1, 0), rx[7:0])
      rd(OP_SR1_READ, 1);
      `CHK("cycle done", 8'h00, rx[7:0])
    end
    $display("test suspend done");
    wr(OP_SR2_WRITE, 8'h00);
    `CHK("lane enable", 1'h0, four_lane_enable)
    `CHK("pins as data", 1'h0, protect_pins_are_data)
    wr(OP_SR1_WRITE, 8'h80);
    protect_pin_n <= 1'h0;
    wr(OP_SR1_WRITE, 8'h3C);
    rd(OP_SR1_READ, 1);
    `CHK("locked write", 8'h80, rx[7:0] & 8'hFD)
    protect_pin_n <= 1'h1;
    wr(OP_SR1_WRITE, 8'h00);
    rd(OP_SR1_READ, 1);
    `CHK("unlocked write", 8'h00, rx[7:0])
    $display("test lock done");
    otp = 3'($urandom % 7 + 1);
    for (int k = 0; k < 2; k++) begin
      wr(OP_SR2_WRITE, k ? 8'h00 : sr2_of(0, 0, 0, otp));
      rd(OP_SR2_READ_B, 1);
      `CHK("one-time lock", sr2_of(0, 0, 0, otp), rx[7:0])
    end
    $display("test one-time lock done");
    tally_and_finish();
  end
endmodule
